// file: lpmc_pkg.sv
// Package for the low-power mode controller: register map, fields, timing
package lpmc_pkg;

	// Register byte offsets on the AXI4-Lite slave
	localparam logic [7:0] OFS_CTRL = 8'h00;
	localparam logic [7:0] OFS_STAT = 8'h04;
	localparam logic [7:0] OFS_WAKE = 8'h08;

	// Control register field positions
	localparam int CTRL_LPRUN_REQ = 0;
	localparam int CTRL_LPRUN_EXIT = 1;
	localparam int CTRL_VREF_OFF = 2;
	localparam int CTRL_FAST_WAKE = 3;
	localparam int CTRL_HALT_ACTIVE = 4;
	localparam int CTRL_LS_EXT = 5;

	// Reset values
	localparam logic [31:0] CTRL_RST = 32'h0000_0000;
	localparam logic [7:0] PERIPH_EN_RST = 8'hff;

	// Timing: clock and wakeup times
	localparam int CLK_HZ = 20_000_000;
	localparam int FAST_WAKE_NS = 5000;
	localparam int SLOW_WAKE_NS = 50000;
	localparam int FAST_WAKE_CYC = (FAST_WAKE_NS * (CLK_HZ / 1_000_000)) / 1000;
	localparam int SLOW_WAKE_CYC = (SLOW_WAKE_NS * (CLK_HZ / 1_000_000)) / 1000;
	localparam int WAKE_CNT_W = 11;

	// Controller modes
	typedef enum logic [2:0] {
		LPMC_RUN,
		LPMC_WAIT,
		LPMC_LPRUN,
		LPMC_LPWAIT,
		LPMC_ACT_HALT,
		LPMC_HALT,
		LPMC_WAKE
	} lpmc_mode_e;

	// Wakeup sources gathered together
	typedef struct packed {
		logic int_irq;
		logic ext_irq;
		logic periph_event;
		logic rtc_irq;
		logic halt_wake_periph;
	} lpmc_wake_s;

	// Clock and supply controls driven out
	typedef struct packed {
		logic cpu_clk_en;
		logic [7:0] periph_clk_en;
		logic rtc_clk_en;
		logic nvm_clk_en;
		logic sys_clk_low_speed;
		logic low_speed_ext_sel;
		logic low_power_regulator_mode;
		logic regulator_ulp;
		logic vref_en;
		logic brownout_monitor_en;
	} lpmc_pwr_s;

endpackage

// file: lpmc_top.sv
// Low-power mode controller with AXI4-Lite register access
// Notes on behaviour
// - Wait stops CPU clock, selected peripherals run
// - Wait exits on interrupt or reset
// - Low-power run: CPU runs on slow clock
// - Low-power run stops flash, regulator ultra-low
// - Low-power run entry/exit by software, reset
// - Wait-for-event in low-power run enters low-power wait
// - Low-power wait equals low-power run, CPU stopped
// - Low-power wait wakes on event or reset
// - Event wake returns to low-power run
// - Active-halt keeps only RTC clock
// - Active-halt exits on RTC, external irq, reset
// - Halt stops clocks, stays powered, keeps RAM
// - Halt exits on external irq, wake peripherals
// - Reference voltage may switch off in halt
// - Fast wake skips reference settle, 5 us
// - Halt entry moves regulator to low-power
// - Reference off also disables brownout monitor
//
// The AXI4-Lite interface to the registers and the address map were decided locally.
`timescale 1ns/1ps
module lpmc_top (
	input wire logic clk_in,
	input wire logic rst_in,
	input wire logic wait_for_interrupt_instr_in,
	input wire logic wait_for_event_instr_in,
	input wire logic halt_instr_in,
	input wire lpmc_pkg::lpmc_wake_s wake_in,
	output lpmc_pkg::lpmc_pwr_s pwr_out,
	output logic [2:0] mode_out,
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready
);

	lpmc_pkg::lpmc_mode_e mode_q, mode_d;
	lpmc_pkg::lpmc_pwr_s pwr_q, pwr_d;
	logic [31:0] ctrl_q;
	logic [7:0] periph_en_q;
	logic [lpmc_pkg::WAKE_CNT_W-1:0] wcnt_q, wcnt_d;
	logic lprun_req_q, lprun_exit_q;
	logic [4:0] wake_seen_q;

	// AXI write and read path state
	logic aw_have_q, w_have_q, bvalid_q;
	logic [7:0] awaddr_q;
	logic [31:0] wdata_q;
	logic [3:0] wstrb_q;
	logic arvalid_ok, rvalid_q;
	logic [31:0] rdata_q;
	logic [1:0] rresp_q, bresp_q;

	// Write channel handshakes and decode
	wire aw_hs = s_axi_awvalid && s_axi_awready;
	wire w_hs = s_axi_wvalid && s_axi_wready;
	wire do_write = aw_have_q && w_have_q && !bvalid_q;
	wire wr_ctrl = do_write && (awaddr_q == lpmc_pkg::OFS_CTRL);
	wire wr_wake = do_write && (awaddr_q == lpmc_pkg::OFS_WAKE);
	wire wr_ok = wr_ctrl || wr_wake;
	assign s_axi_awready = !aw_have_q && !bvalid_q;
	assign s_axi_wready = !w_have_q && !bvalid_q;
	assign s_axi_bvalid = bvalid_q;
	assign s_axi_bresp = bresp_q;

	// Read channel decode
	wire ar_hs = s_axi_arvalid && s_axi_arready;
	assign s_axi_arready = !rvalid_q;
	assign s_axi_rvalid = rvalid_q;
	assign s_axi_rdata = rdata_q;
	assign s_axi_rresp = rresp_q;
	assign arvalid_ok = (s_axi_araddr == lpmc_pkg::OFS_CTRL) ||
		(s_axi_araddr == lpmc_pkg::OFS_STAT) ||
		(s_axi_araddr == lpmc_pkg::OFS_WAKE);
	wire [31:0] stat_word = {21'h0, wake_seen_q, pwr_q.vref_en,
		pwr_q.low_power_regulator_mode, mode_q == lpmc_pkg::LPMC_WAKE,
		mode_q};
	wire [31:0] rd_mux = (s_axi_araddr == lpmc_pkg::OFS_CTRL) ? ctrl_q :
		(s_axi_araddr == lpmc_pkg::OFS_STAT) ? stat_word :
		(s_axi_araddr == lpmc_pkg::OFS_WAKE) ? {24'h0, periph_en_q} :
		32'h0000_0000;

	// Byte-lane merge for control writes
	wire [31:0] wmask = {{8{wstrb_q[3]}}, {8{wstrb_q[2]}},
		{8{wstrb_q[1]}}, {8{wstrb_q[0]}}};
	wire [31:0] ctrl_wr = (ctrl_q & ~wmask) | (wdata_q & wmask);

	// Control bits picked out
	wire vref_off_sel = ctrl_q[lpmc_pkg::CTRL_VREF_OFF];
	wire fast_wake = ctrl_q[lpmc_pkg::CTRL_FAST_WAKE];
	wire halt_active = ctrl_q[lpmc_pkg::CTRL_HALT_ACTIVE];
	wire ls_ext = ctrl_q[lpmc_pkg::CTRL_LS_EXT];
	wire [4:0] wake_vec = wake_in;

	// AXI write address/data capture and response
	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			aw_have_q <= 1'b0;
			w_have_q <= 1'b0;
			bvalid_q <= 1'b0;
			bresp_q <= 2'b00;
			awaddr_q <= 8'h00;
			wdata_q <= 32'h0000_0000;
			wstrb_q <= 4'h0;
		end else begin
			if (aw_hs) begin
				aw_have_q <= 1'b1;
				awaddr_q <= s_axi_awaddr;
			end
			if (w_hs) begin
				w_have_q <= 1'b1;
				wdata_q <= s_axi_wdata;
				wstrb_q <= s_axi_wstrb;
			end
			if (do_write) begin
				aw_have_q <= 1'b0;
				w_have_q <= 1'b0;
				bvalid_q <= 1'b1;
				bresp_q <= wr_ok ? 2'b00 : 2'b10;
			end else if (bvalid_q && s_axi_bready) begin
				bvalid_q <= 1'b0;
			end
		end
	end

	// AXI read response
	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			rvalid_q <= 1'b0;
			rdata_q <= 32'h0000_0000;
			rresp_q <= 2'b00;
		end else if (ar_hs) begin
			rvalid_q <= 1'b1;
			rdata_q <= rd_mux;
			rresp_q <= arvalid_ok ? 2'b00 : 2'b10;
		end else if (rvalid_q && s_axi_rready) begin
			rvalid_q <= 1'b0;
		end
	end

	// Configuration registers; request bits pulse for one cycle after the write and are not stored
	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			ctrl_q <= lpmc_pkg::CTRL_RST;
			periph_en_q <= lpmc_pkg::PERIPH_EN_RST;
			lprun_req_q <= 1'b0;
			lprun_exit_q <= 1'b0;
		end else begin
			if (wr_ctrl) begin
				ctrl_q <= ctrl_wr & 32'h0000_003c;
			end
			if (wr_wake) begin
				periph_en_q <= wdata_q[7:0];
			end
			lprun_req_q <= wr_ctrl && ctrl_wr[lpmc_pkg::CTRL_LPRUN_REQ];
			lprun_exit_q <= wr_ctrl && ctrl_wr[lpmc_pkg::CTRL_LPRUN_EXIT];
		end
	end

	// Sticky record of which wakeup line ended the last low-power mode
	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			wake_seen_q <= 5'h00;
		end else if (mode_q != mode_d && mode_q != lpmc_pkg::LPMC_RUN &&
			mode_q != lpmc_pkg::LPMC_LPRUN && mode_q != lpmc_pkg::LPMC_WAKE) begin
			wake_seen_q <= wake_vec;
		end
	end

	// Mode sequencing
	always_comb begin
		mode_d = mode_q;
		wcnt_d = wcnt_q;
		case (mode_q)
			lpmc_pkg::LPMC_RUN: begin
				if (lprun_req_q) begin
					mode_d = lpmc_pkg::LPMC_LPRUN;
				end else if (wait_for_interrupt_instr_in ||
					wait_for_event_instr_in) begin
					mode_d = lpmc_pkg::LPMC_WAIT;
				end else if (halt_instr_in) begin
					mode_d = halt_active ? lpmc_pkg::LPMC_ACT_HALT :
						lpmc_pkg::LPMC_HALT;
				end
			end
			lpmc_pkg::LPMC_WAIT: begin
				if (wake_in.int_irq || wake_in.ext_irq) begin
					mode_d = lpmc_pkg::LPMC_RUN;
				end
			end
			lpmc_pkg::LPMC_LPRUN: begin
				if (lprun_exit_q) begin
					mode_d = lpmc_pkg::LPMC_RUN;
				end else if (wait_for_event_instr_in) begin
					mode_d = lpmc_pkg::LPMC_LPWAIT;
				end
			end
			// Event wakes back to low-power run
			lpmc_pkg::LPMC_LPWAIT: begin
				if (wake_in.periph_event) begin
					mode_d = lpmc_pkg::LPMC_LPRUN;
				end
			end
			lpmc_pkg::LPMC_ACT_HALT: begin
				if (wake_in.rtc_irq || wake_in.ext_irq) begin
					mode_d = lpmc_pkg::LPMC_WAKE;
					wcnt_d = '0;
				end
			end
			lpmc_pkg::LPMC_HALT: begin
				if (wake_in.ext_irq || wake_in.halt_wake_periph) begin
					mode_d = lpmc_pkg::LPMC_WAKE;
					wcnt_d = '0;
				end
			end
			// Settle time, shortened by fast wake
			lpmc_pkg::LPMC_WAKE: begin
				wcnt_d = wcnt_q + 1'b1;
				if ((fast_wake && wcnt_q ==
					lpmc_pkg::WAKE_CNT_W'(lpmc_pkg::FAST_WAKE_CYC - 1)) ||
					wcnt_q ==
					lpmc_pkg::WAKE_CNT_W'(lpmc_pkg::SLOW_WAKE_CYC - 1)) begin
					mode_d = lpmc_pkg::LPMC_RUN;
				end
			end
			default: mode_d = lpmc_pkg::LPMC_RUN;
		endcase
	end

	// Clock and supply outputs per mode
	always_comb begin
		pwr_d.cpu_clk_en = 1'b1;
		pwr_d.periph_clk_en = 8'hff;
		pwr_d.rtc_clk_en = 1'b1;
		pwr_d.nvm_clk_en = 1'b1;
		pwr_d.sys_clk_low_speed = 1'b0;
		pwr_d.low_speed_ext_sel = ls_ext;
		pwr_d.low_power_regulator_mode = 1'b0;
		pwr_d.regulator_ulp = 1'b0;
		pwr_d.vref_en = 1'b1;
		pwr_d.brownout_monitor_en = 1'b1;
		case (mode_d)
			lpmc_pkg::LPMC_WAIT: begin
				pwr_d.cpu_clk_en = 1'b0;
				pwr_d.periph_clk_en = periph_en_q;
			end
			// Slow clock, flash off, ULP regulator
			lpmc_pkg::LPMC_LPRUN, lpmc_pkg::LPMC_LPWAIT: begin
				pwr_d.cpu_clk_en = mode_d == lpmc_pkg::LPMC_LPRUN;
				pwr_d.periph_clk_en = periph_en_q;
				pwr_d.nvm_clk_en = 1'b0;
				pwr_d.sys_clk_low_speed = 1'b1;
				pwr_d.low_power_regulator_mode = 1'b1;
				pwr_d.regulator_ulp = 1'b1;
			end
			lpmc_pkg::LPMC_ACT_HALT, lpmc_pkg::LPMC_HALT: begin
				pwr_d.cpu_clk_en = 1'b0;
				pwr_d.periph_clk_en = 8'h00;
				pwr_d.nvm_clk_en = 1'b0;
				pwr_d.rtc_clk_en = mode_d == lpmc_pkg::LPMC_ACT_HALT;
				pwr_d.low_power_regulator_mode = 1'b1;
				pwr_d.vref_en = !(vref_off_sel &&
					mode_d == lpmc_pkg::LPMC_HALT);
				pwr_d.brownout_monitor_en = pwr_d.vref_en;
			end
			lpmc_pkg::LPMC_WAKE: begin
				pwr_d.cpu_clk_en = 1'b0;
				pwr_d.periph_clk_en = 8'h00;
				pwr_d.nvm_clk_en = 1'b0;
			end
			default: begin
			end
		endcase
	end

	// Reset returns to run with clocks on
	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			mode_q <= lpmc_pkg::LPMC_RUN;
			wcnt_q <= '0;
			pwr_q <= '{cpu_clk_en: 1'b1, periph_clk_en: 8'hff,
				rtc_clk_en: 1'b1, nvm_clk_en: 1'b1, sys_clk_low_speed: 1'b0,
				low_speed_ext_sel: 1'b0, low_power_regulator_mode: 1'b0,
				regulator_ulp: 1'b0, vref_en: 1'b1, brownout_monitor_en: 1'b1};
		end else begin
			mode_q <= mode_d;
			wcnt_q <= wcnt_d;
			pwr_q <= pwr_d;
		end
	end

	assign pwr_out = pwr_q;
	assign mode_out = mode_q;

endmodule

// file: lpmc_cpu_model.sv
// CPU core stand-in issuing sleep instructions as one-cycle levels
`timescale 1ns/1ps
module lpmc_cpu_model (
	input wire logic clk_in,
	input wire logic [1:0] op_in,
	output logic wfi_out,
	output logic wfe_out,
	output logic halt_out
);
	// The model has no interrupt input
	// Only instructions leave the core; interrupt use is left to the bench
	always_ff @(posedge clk_in) begin
		wfi_out <= op_in == 2'h1;
		wfe_out <= op_in == 2'h2;
		halt_out <= op_in == 2'h3;
	end
endmodule

// file: lpmc_chk_assertions.sv
// Checker of the mode and power outputs of the mode controller
`timescale 1ns/1ps
module lpmc_chk (
	input wire logic clk_in,
	input wire logic rst_in,
	input wire lpmc_pkg::lpmc_wake_s wake_in,
	input wire lpmc_pkg::lpmc_pwr_s pwr_out,
	input wire logic [2:0] mode_out
);
	default clocking cb @(posedge clk_in); endclocking
	default disable iff (rst_in);
	// Clock gating in the sleep modes and exits from wait, low-power wait and both halts
	wait_cpu_off_a: assert property (mode_out == 3'h1 |->
		!pwr_out.cpu_clk_en) else $error("CPU clock runs in wait");
	wait_exit_a: assert property (mode_out == 3'h1 &&
		(wake_in.int_irq || wake_in.ext_irq) |=> mode_out == 3'h0)
		else $error("Wait not left on interrupt");
	lprun_cfg_a: assert property (mode_out == 3'h2 |->
		pwr_out.cpu_clk_en && pwr_out.sys_clk_low_speed &&
		!pwr_out.nvm_clk_en && pwr_out.regulator_ulp)
		else $error("Bad low-power run setup");
	lpwait_cfg_a: assert property (mode_out == 3'h3 |->
		!pwr_out.cpu_clk_en && pwr_out.sys_clk_low_speed &&
		!pwr_out.nvm_clk_en) else $error("Bad low-power wait setup");
	lpwait_event_a: assert property (mode_out == 3'h3 &&
		wake_in.periph_event |=> mode_out == 3'h2)
		else $error("Event did not return to low-power run");
	lpwait_hold_a: assert property (mode_out == 3'h3 &&
		!wake_in.periph_event |=> $stable(mode_out))
		else $error("Low-power wait left without event");
	ahalt_clk_a: assert property (mode_out == 3'h4 |->
		!pwr_out.cpu_clk_en && pwr_out.periph_clk_en == 8'h00 &&
		pwr_out.rtc_clk_en && pwr_out.low_power_regulator_mode)
		else $error("Bad active-halt clocks");
	ahalt_exit_a: assert property (mode_out == 3'h4 &&
		(wake_in.rtc_irq || wake_in.ext_irq) |=> mode_out == 3'h6)
		else $error("Active-halt did not wake");
	halt_clk_a: assert property (mode_out == 3'h5 |->
		!pwr_out.cpu_clk_en && pwr_out.periph_clk_en == 8'h00 &&
		pwr_out.low_power_regulator_mode) else $error("Bad halt clocks");
	halt_exit_a: assert property (mode_out == 3'h5 &&
		(wake_in.ext_irq || wake_in.halt_wake_periph) |=>
		mode_out == 3'h6) else $error("Halt did not wake");
	ref_brownout_a: assert property (!pwr_out.vref_en |->
		!pwr_out.brownout_monitor_en) else $error("Monitor on, ref off");
	reset_run_a: assert property ($fell(rst_in) |->
		mode_out == 3'h0 && pwr_out.cpu_clk_en &&
		pwr_out.periph_clk_en == 8'hff) else $error("Reset not in run");
endmodule
bind lpmc_top lpmc_chk u_chk (.clk_in(clk_in), .rst_in(rst_in),
	.wake_in(wake_in), .pwr_out(pwr_out), .mode_out(mode_out));

// file: tb.sv
// Bench for the mode controller: bus tasks, mode walks and checks
`timescale 1ns/1ps
module tb;
	logic clk_in = 0;
	logic rst_in = 1;
	logic [1:0] op = 0;
	logic wait_for_interrupt_instr, wait_for_event_instr, hlt, awv = 0, wv = 0, bry = 0, arv = 0, rry = 0;
	logic awr, wrd, bv, arr, rv;
	lpmc_pkg::lpmc_wake_s wk = '0;
	lpmc_pkg::lpmc_pwr_s pw;
	logic [2:0] md;
	logic [7:0] awa = 0, ara = 0, pe;
	logic [31:0] wd = 0, rdt, v;
	logic [1:0] br, rr, rsp;
	logic [3:0] stb = 4'hf;
	logic [31:0] cf [3] = '{32'hc, 32'h10, 32'h0};
	logic [4:0] ws [3] = '{5'h08, 5'h02, 5'h01};
	int fails = 0, checked = 0, n;
	lpmc_cpu_model u_cpu (.clk_in(clk_in), .op_in(op), .wfi_out(wait_for_interrupt_instr),
		.wfe_out(wait_for_event_instr), .halt_out(hlt));
	lpmc_top dut (.clk_in(clk_in), .rst_in(rst_in),
		.wait_for_interrupt_instr_in(wait_for_interrupt_instr), .wait_for_event_instr_in(wait_for_event_instr),
		.halt_instr_in(hlt), .wake_in(wk), .pwr_out(pw), .mode_out(md),
		.s_axi_awaddr(awa), .s_axi_awvalid(awv), .s_axi_awready(awr),
		.s_axi_wdata(wd), .s_axi_wstrb(stb), .s_axi_wvalid(wv),
		.s_axi_wready(wrd), .s_axi_bresp(br), .s_axi_bvalid(bv),
		.s_axi_bready(bry), .s_axi_araddr(ara), .s_axi_arvalid(arv),
		.s_axi_arready(arr), .s_axi_rdata(rdt), .s_axi_rresp(rr),
		.s_axi_rvalid(rv), .s_axi_rready(rry));
	// Free-running system clock
	initial begin
		forever #25 clk_in = ~clk_in;
	end
	task chk(input logic [31:0] s, input logic [31:0] e);
		checked++;
		if (s !== e) begin
			fails++;
			$display("[FAIL] %0t seen %h expected %h", $time, s, e);
		end
	endtask
	task give_verdict;
		if (fails == 0 && checked > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	// Write: handshakes are judged before the edge, released on it
	task bus_wr(input logic [7:0] a, input logic [31:0] d);
		logic ak, dk, bk;
		@(posedge clk_in);
		awa <= a;
		wd <= d;
		awv <= 1;
		wv <= 1;
		bry <= 1;
		do begin
			@(negedge clk_in);
			ak = awv && awr;
			dk = wv && wrd;
			bk = bv;
			rsp = br;
			@(posedge clk_in);
			if (ak) awv <= 0;
			if (dk) wv <= 0;
		end while (!bk);
		bry <= 0;
	endtask
	task bus_rd(input logic [7:0] a);
		logic ak, rk;
		@(posedge clk_in);
		ara <= a;
		arv <= 1;
		rry <= 1;
		do begin
			@(negedge clk_in);
			ak = arv && arr;
			rk = rv;
			v = rdt;
			rsp = rr;
			@(posedge clk_in);
			if (ak) arv <= 0;
		end while (!rk);
		rry <= 0;
	endtask
	// One-cycle instruction from the core stand-in
	task cpu(input logic [1:0] o);
		@(posedge clk_in);
		op <= o;
		@(posedge clk_in);
		op <= 0;
	endtask
	// Wait a bounded time for a mode, then compare it
	task go(input logic [2:0] m);
		n = 0;
		do begin
			@(negedge clk_in);
			n++;
		end while (md !== m && n < 50);
		chk(md, m);
		@(posedge clk_in);
	endtask
	initial begin
		#1000000;
		fails++;
		give_verdict;
	end
	initial begin
		void'($urandom(32'h735e2747));
		repeat (8) @(posedge clk_in);
		rst_in <= 0;
		@(negedge clk_in);
		chk(32'(pw), 32'h1ffc3);
		pe = 8'($urandom);
		bus_wr(lpmc_pkg::OFS_WAKE, {24'h0, pe});
		chk(rsp, 2'h0);
		bus_rd(lpmc_pkg::OFS_WAKE);
		chk(v[7:0], pe);
		for (int i = 0; i < 2; i++) begin
			cpu(i ? 2'h2 : 2'h1);
			go(3'h1);
			chk({pw.cpu_clk_en, pw.periph_clk_en}, {1'b0, pe});
			wk <= i ? 5'h08 : 5'h10;
			go(3'h0);
			wk <= 0;
		end
		// Low-power run request with the external slow oscillator picked
		bus_wr(lpmc_pkg::OFS_CTRL, 32'h21);
		go(3'h2);
		chk({pw.regulator_ulp, pw.nvm_clk_en,
			pw.sys_clk_low_speed, pw.low_speed_ext_sel, pw.cpu_clk_en},
			5'h17);
		bus_rd(lpmc_pkg::OFS_CTRL);
		chk(v, 32'h20);
		wk <= 5'h18;
		cpu(2'h3);
		repeat (3) @(posedge clk_in);
		go(3'h2);
		wk <= 0;
		cpu(2'h2);
		go(3'h3);
		wk <= 5'h18;
		repeat (3) @(posedge clk_in);
		go(3'h3);
		wk <= 5'h04;
		go(3'h2);
		wk <= 0;
		bus_wr(lpmc_pkg::OFS_CTRL, 32'h2);
		go(3'h0);
		for (int i = 0; i < 3; i++) begin
			bus_wr(lpmc_pkg::OFS_CTRL, cf[i]);
			cpu(2'h3);
			go(cf[i][4] ? 3'h4 : 3'h5);
			chk({pw.vref_en, pw.low_power_regulator_mode,
				pw.rtc_clk_en}, {!cf[i][2], 1'b1, cf[i][4]});
			wk <= ws[i];
			go(3'h6);
			wk <= 0;
			n = 0;
			do begin
				@(negedge clk_in);
				n++;
			end while (md === 3'h6 && n < 2000);
			chk(n, cf[i][3] ? lpmc_pkg::FAST_WAKE_CYC :
				lpmc_pkg::SLOW_WAKE_CYC);
			// Status shows run mode and the line that woke the core
			bus_rd(lpmc_pkg::OFS_STAT);
			chk(v, {21'h0, ws[i], 6'h20});
		end
		cpu(2'h3);
		go(3'h5);
		rst_in <= 1;
		@(posedge clk_in);
		rst_in <= 0;
		stb <= 4'h0;
		@(negedge clk_in);
		chk(32'(pw), 32'h1ffc3);
		chk(md, 3'h0);
		// A write with no byte lanes must not request low-power run
		bus_wr(lpmc_pkg::OFS_CTRL, 32'h3d);
		stb <= 4'hf;
		bus_rd(lpmc_pkg::OFS_CTRL);
		chk(v, 32'h0);
		go(3'h0);
		bus_rd(8'h0c);
		chk(rsp, 2'h2);
		bus_wr(8'h0c, 32'($urandom));
		chk(rsp, 2'h2);
		give_verdict;
	end
endmodule
